// >>> core/sqi_cfg.svh
`ifndef SQI_CFG_SVH
`define SQI_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SQI_OFS_CTRL   4'h0
`define SQI_OFS_GAP    4'h4
`define SQI_OFS_TEST   4'h8
`define SQI_OFS_STAT   4'hc
// ----------------------------------------------------------------
// ctrl field positions
// ----------------------------------------------------------------
`define SQI_CTRL_SEL0  1:0
`define SQI_CTRL_SEL1  3:2
`define SQI_CTRL_PHS   5:4
`define SQI_CTRL_HALF  6
// ----------------------------------------------------------------
// three-level pin codes
// ----------------------------------------------------------------
`define SQI_LVL_LO     2'h0
`define SQI_LVL_OPEN   2'h1
`define SQI_LVL_HI     2'h2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SQI_RST_SEL    2'h2
`define SQI_RST_PHS    2'h0
`define SQI_RST_GAP    8'h02
`define SQI_RST_TMODE  2'h3
`endif

// >>> core/sqi_pkg.sv
package sqi_pkg;
  // decoded resolution setting
  typedef struct packed {
    logic [4:0] factor;   // interpolation factor
    logic [6:0] steps;    // core steps per input cycle
    logic [2:0] div_log;  // log2 of internal divisor
  } sqi_res_type;
  // whole state of the block
  typedef struct packed {
    logic [1:0] cfg_sel0;
    logic [1:0] cfg_sel1;
    logic [1:0] cfg_phs;
    logic       cfg_half;
    logic [1:0] act_sel0;
    logic [1:0] act_sel1;
    logic [1:0] act_phs;
    logic       act_half;
    logic [7:0] gap;
    logic [1:0] tmode;
    logic       test_en;
    logic       strap_done;
    logic       started;
    logic       primed;
    logic [5:0] trk;
    logic       dir_dn;
    logic [7:0] gap_cnt;
    logic       qa;
    logic       qb;
    logic       qz;
    logic       wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] rdata;
  } sqi_state_type;
endpackage

// >>> core/sqi_top.sv
`timescale 1ns/1ps
`include "sqi_cfg.svh"
module sqi_top
  import sqi_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // angle from converter core
  input  wire logic [5:0]  angle_pos,
  input  wire logic        index_gate_pos,
  input  wire logic        index_gate_neg,
  input  wire logic        test_strap,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // incremental outputs
  output logic             qa,
  output logic             qb,
  output logic             qz
);
  import sqi_pkg::*;

  // ----------------------------------------------------------------
  // behaviour notes for users of this block
  // ----------------------------------------------------------------
  // angle input
  //   the angle is a level, one of 64 positions per input cycle;
  //   it is scaled to the core step count of the chosen factor
  //   (64, 48 or 40 steps per input cycle) before tracking.
  //   a jump of several steps is walked off one core step at a time,
  //   so a large jump takes (gap + 1) clocks per core step to settle.
  // spacing
  //   every accepted core step reloads the gap counter; no further
  //   step is taken until it has run down to zero.
  //   output edges are spaced by (gap + 1) clocks times the divisor,
  //   which keeps a slow counter on the far side from missing edges.
  //   a gap of zero lets one core step through on every clock.
  // hysteresis
  //   moving on in the same direction needs one core step;
  //   turning back needs two, so a static or jittering angle
  //   sitting on a step border never toggles the outputs.
  //   the price is a lag of one core step after each reversal.
  // index and msb
  //   the index sits at one eighth of the input cycle (45 degrees);
  //   it is the whole output cycle that holds that core step,
  //   narrowed by both quadrature lines or by one line alone: a, or b with the high phase setting.
  //   the zero gate is a plain level; a grant that starts or ends
  //   inside the index window clips the pulse.
  //   with the open phase setting qz carries the converter msb,
  //   high for half an input cycle starting at the index step.
  // configuration
  //   a write to ctrl takes effect two clocks later: the selects
  //   are taken over, then the tracker is loaded from the angle.
  //   the outputs may jump once at that point, since the new
  //   factor gives a new pattern; a far-side counter should be
  //   cleared after any change of factor.
  //   the test strap is caught only on the first clock after reset.
  // bus
  //   no wait states and no error response; read data is taken in
  //   the address phase and stands until the next read.

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------

  // resolution from the two three-level selects
  function automatic sqi_res_type res_dec(input logic [1:0] s1,
                                          input logic [1:0] s0);
    sqi_res_type r;
    r = '{factor: 5'd16, steps: 7'd64, div_log: 3'd0};
    unique case ({s1, s0})
      {`SQI_LVL_HI, `SQI_LVL_HI}:     r = '{5'd16, 7'd64, 3'd0};
      {`SQI_LVL_HI, `SQI_LVL_OPEN}:   r = '{5'd12, 7'd48, 3'd0};
      {`SQI_LVL_HI, `SQI_LVL_LO}:     r = '{5'd10, 7'd40, 3'd0};
      {`SQI_LVL_OPEN, `SQI_LVL_HI}:   r = '{5'd8, 7'd64, 3'd1};
      {`SQI_LVL_OPEN, `SQI_LVL_OPEN}: r = '{5'd5, 7'd40, 3'd1};
      {`SQI_LVL_OPEN, `SQI_LVL_LO}:   r = '{5'd4, 7'd64, 3'd2};
      {`SQI_LVL_LO, `SQI_LVL_HI}:     r = '{5'd3, 7'd48, 3'd2};
      {`SQI_LVL_LO, `SQI_LVL_OPEN}:   r = '{5'd2, 7'd64, 3'd3};
      {`SQI_LVL_LO, `SQI_LVL_LO}:     r = '{5'd1, 7'd64, 3'd4};
      default:                        r = '{5'd16, 7'd64, 3'd0};
    endcase
    return r;
  endfunction

  // step count modulo the core steps of one input cycle
  function automatic logic [5:0] wrap(input logic [6:0] v,
                                      input logic [6:0] m);
    logic [6:0] w;
    w = (v >= m) ? 7'(v - m) : v;
    return w[5:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sqi_state_type st_q;    // registered state
  sqi_state_type st_d;    // next state
  sqi_res_type   res;     // active resolution
  logic [11:0]   scaled;  // angle scaled to core steps
  logic [5:0]    fine;    // angle in core steps
  logic [6:0]    diff;    // fine minus tracked, modulo
  logic [6:0]    half_m;  // half an input cycle in steps
  logic          go_up;   // accepted step forward
  logic          go_dn;   // accepted step backward
  logic [5:0]    trk_n;   // tracked step after this cycle
  logic [5:0]    oc;      // output edge count
  logic [5:0]    z_oc;    // output edge count at index
  logic [5:0]    z_trk;   // core step at index
  logic          qa_r;    // a before phase swap
  logic          qb_r;    // b before phase swap
  logic          zone;    // inside the index cycle
  logic          idx;     // gated index pulse
  logic          msb;     // converter msb
  logic          gate;    // zero comparator grant
  logic          addr_ok; // valid address phase
  logic [31:0]   rd_mux;  // read data for the address

  // ----------------------------------------------------------------
  // angle tracking with hysteresis
  // ----------------------------------------------------------------

  // distance from tracked step to present angle
  always_comb
  begin
    res    = res_dec(st_q.act_sel1, st_q.act_sel0);
    scaled = 12'(angle_pos) * 12'(res.steps);
    fine   = scaled[11:6];
    diff   = 7'(fine) + res.steps - 7'(st_q.trk);
    if (diff >= res.steps)
    begin
      diff = 7'(diff - res.steps);
    end
    half_m = {1'b0, res.steps[6:1]};
    // forward keeps direction at one step, reversal needs two
    if (!st_q.dir_dn)
    begin
      go_up = (diff >= 7'd1) && (diff < half_m);
      go_dn = (diff >= half_m) && (diff <= 7'(res.steps - 7'd2));
    end
    else
    begin
      go_dn = (diff >= half_m);
      go_up = (diff >= 7'd2) && (diff < half_m);
    end
    // the core gap holds back every step
    if (!st_q.primed || st_q.gap_cnt != 8'h00)
    begin
      go_up = 1'b0;
      go_dn = 1'b0;
    end
    if (go_up)
    begin
      trk_n = wrap(7'(st_q.trk) + 7'd1, res.steps);
    end
    else if (go_dn)
    begin
      trk_n = wrap(7'(st_q.trk) + res.steps - 7'd1, res.steps);
    end
    else
    begin
      trk_n = st_q.trk;
    end
  end

  // ----------------------------------------------------------------
  // quadrature, index and msb
  // ----------------------------------------------------------------

  // output pattern for the next tracked step
  always_comb
  begin
    oc    = trk_n >> res.div_log;
    z_trk = {2'b00, res.steps[6:3]};
    z_oc  = z_trk >> res.div_log;
    // gray order 00,01,11,10 makes b lead on rising count
    qa_r  = oc[1];
    qb_r  = oc[1] ^ oc[0];
    zone  = (oc[5:2] == z_oc[5:2]);
    gate  = index_gate_pos & ~index_gate_neg;
    if (st_q.act_half)
    begin
      idx = gate & zone & qa_r;
    end
    else
    begin
      idx = gate & zone & qa_r & qb_r;
    end
    msb = (7'(wrap(7'(trk_n) + res.steps - 7'(z_trk), res.steps)) < half_m);
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // read value for the current address phase
  always_comb
  begin
    addr_ok = hsel & hready & htrans[1];
    rd_mux  = 32'h0000_0000;
    unique case (haddr[3:0])
      `SQI_OFS_CTRL:
      begin
        rd_mux[`SQI_CTRL_SEL0] = st_q.cfg_sel0;
        rd_mux[`SQI_CTRL_SEL1] = st_q.cfg_sel1;
        rd_mux[`SQI_CTRL_PHS]  = st_q.cfg_phs;
        rd_mux[`SQI_CTRL_HALF] = st_q.cfg_half;
      end
      `SQI_OFS_GAP:  rd_mux[7:0] = st_q.gap;
      `SQI_OFS_TEST: rd_mux[2:0] = {st_q.test_en, st_q.tmode};
      `SQI_OFS_STAT:
      begin
        rd_mux[5:0]   = st_q.trk;
        rd_mux[6]     = st_q.dir_dn;
        rd_mux[9:7]   = {st_q.qz, st_q.qb, st_q.qa};
        rd_mux[20:16] = res.factor;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:4] != 28'h000_0000)
    begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // one step of all state
  always_comb
  begin
    st_d = st_q;
    // strap is caught once after reset, never again
    if (!st_q.strap_done)
    begin
      st_d.strap_done = 1'b1;
      st_d.test_en    = test_strap;
    end
    // first cycle after reset or ctrl write: catch selects
    if (!st_q.started)
    begin
      st_d.started  = 1'b1;
      st_d.act_sel0 = st_q.cfg_sel0;
      st_d.act_sel1 = st_q.cfg_sel1;
      st_d.act_phs  = st_q.cfg_phs;
      st_d.act_half = st_q.cfg_half;
    end
    else if (!st_q.primed)
    begin
      // take the angle as start point without any edge
      st_d.primed = 1'b1;
      st_d.trk    = fine;
    end
    // tracker and gap counter
    if (go_up || go_dn)
    begin
      st_d.trk     = trk_n;
      st_d.dir_dn  = go_dn;
      st_d.gap_cnt = st_q.gap;
    end
    else if (st_q.gap_cnt != 8'h00)
    begin
      st_d.gap_cnt = 8'(st_q.gap_cnt - 8'h01);
    end
    // outputs follow within one clock
    if (st_q.primed)
    begin
      if (st_q.act_phs == `SQI_LVL_HI)
      begin
        st_d.qa = qb_r;
        st_d.qb = qa_r;
      end
      else
      begin
        st_d.qa = qa_r;
        st_d.qb = qb_r;
      end
      st_d.qz = (st_q.act_phs == `SQI_LVL_OPEN) ? msb : idx;
    end
    // bus: read data captured in the address phase
    st_d.wr_pend = addr_ok & hwrite & (haddr[31:4] == 28'h000_0000);
    st_d.wr_addr = haddr[3:0];
    if (addr_ok && !hwrite)
    begin
      st_d.rdata = rd_mux;
    end
    // bus: write in the data phase
    if (st_q.wr_pend)
    begin
      unique case (st_q.wr_addr)
        `SQI_OFS_CTRL:
        begin
          st_d.cfg_sel0 = hwdata[`SQI_CTRL_SEL0];
          st_d.cfg_sel1 = hwdata[`SQI_CTRL_SEL1];
          st_d.cfg_phs  = hwdata[`SQI_CTRL_PHS];
          st_d.cfg_half = hwdata[`SQI_CTRL_HALF];
          st_d.started  = 1'b0;
          st_d.primed   = 1'b0;
        end
        `SQI_OFS_GAP: st_d.gap = hwdata[7:0];
        `SQI_OFS_TEST:
        begin
          if (st_q.test_en)
          begin
            st_d.tmode = hwdata[1:0];
          end
        end
        default: st_d.rdata = st_q.rdata;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // synchronous reset, frozen while enable is low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q          <= '0;
      st_q.cfg_sel0 <= `SQI_RST_SEL;
      st_q.cfg_sel1 <= `SQI_RST_SEL;
      st_q.act_sel0 <= `SQI_RST_SEL;
      st_q.act_sel1 <= `SQI_RST_SEL;
      st_q.cfg_phs  <= `SQI_RST_PHS;
      st_q.act_phs  <= `SQI_RST_PHS;
      st_q.gap      <= `SQI_RST_GAP;
      st_q.tmode    <= `SQI_RST_TMODE;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign qa        = st_q.qa;
  assign qb        = st_q.qb;
  assign qz        = st_q.qz;
  assign hrdata    = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// >>> verif/sqi_counter_model.sv
`timescale 1ns/1ps
module sqi_counter_model
(
  // clock, reset, clear
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clr,
  // lines from the block
  input  wire logic qa,
  input  wire logic qb,
  input  wire logic qz,
  // tallies
  output int        pos,
  output int        zrise,
  output int        min_gap
);
  logic [1:0] ph;    // a/b phase index
  logic [1:0] ph_q;  // last phase index
  logic       z_q;   // last index level
  int         since; // clocks since edge
  // gray order, b leading a counts up
  assign ph = {qa, qa ^ qb};
  // decode edges and time their spacing
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pos     <= 0;
      zrise   <= 0;
      min_gap <= 1000;
      since   <= 0;
      ph_q    <= 2'h0;
      z_q     <= 1'b0;
    end
    else
    begin
      since <= since + 1;
      ph_q  <= ph;
      z_q   <= qz;
      if (qz && !z_q)
        zrise <= zrise + 1;
      if (clr)
        min_gap <= 1000;
      if (ph != ph_q)
      begin
        since <= 0;
        if (!clr && since + 1 < min_gap)
          min_gap <= since + 1;
        if (ph == ph_q + 2'h1)
          pos <= pos + 1;
        else
          pos <= pos - 1;
      end
    end
  end
endmodule

// >>> verif/sqi_top_sva.sv
`timescale 1ns/1ps
module sqi_top_chk
(
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // angle and zero gate
  input wire logic [5:0]  angle_pos,
  input wire logic        index_gate_pos,
  input wire logic        index_gate_neg,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // outputs
  input wire logic        qa,
  input wire logic        qb,
  input wire logic        qz
);
  logic       take;    // address phase taken
  logic       grant;   // zero gate grants
  logic       idx;     // qz carries index
  logic       wr_q;    // ctrl write pending
  logic [6:0] ctrl_q;  // ctrl shadow
  logic [7:0] still_q; // quiet clocks, saturating
  logic [2:0] settle_q; // clocks left to settle after ctrl write
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  assign take  = hsel && hready && htrans[1];
  assign grant = index_gate_pos && !index_gate_neg;
  assign idx   = ctrl_q[5:4] != 2'h1;
  // shadow ctrl, count quiet cycles
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_q    <= 1'b0;
      ctrl_q  <= 7'h0a;
      still_q <= 8'h00;
      settle_q <= 3'h0;
    end
    else
    begin
      if (wr_q)
        settle_q <= 3'h7;
      else if (settle_q != 3'h0)
        settle_q <= settle_q - 3'h1;
      wr_q <= take && hwrite && haddr == 32'h0;
      if (wr_q)
        ctrl_q <= hwdata[6:0];
      if (take || $changed(angle_pos) || $changed(grant))
        still_q <= 8'h00;
      else if (still_q != 8'hff)
        still_q <= still_q + 8'h01;
    end
  end
  property p_quad; settle_q == 3'h0 && $changed(qa) |-> $stable(qb); endproperty
  a_quad: assert property (p_quad) else $error("a and b moved together");
  property p_static; still_q > 8'hc8 |-> $stable(qa) && $stable(qb) && $stable(qz); endproperty
  a_static: assert property (p_static) else $error("output moved at rest");
  property p_quarter; $rose(qz) && idx && !ctrl_q[6] |-> qa && qb; endproperty
  a_quarter: assert property (p_quarter) else $error("index outside a and b");
  property p_half; $rose(qz) && idx |-> qa; endproperty
  a_half: assert property (p_half) else $error("index outside a");
  property p_gate; $rose(qz) && idx |-> $past(grant); endproperty
  a_gate: assert property (p_gate) else $error("index without grant");
  property p_rst; disable iff (1'b0) sys_rst |=> !qa && !qb && !qz; endproperty
  a_rst: assert property (p_rst) else $error("outputs high after reset");
  property p_unmapped; take && !hwrite && haddr[31:4] != 28'h0 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error");
endmodule
bind sqi_top sqi_top_chk sqi_top_chk_inst (.clock(clock), .sys_rst(sys_rst),
  .angle_pos(angle_pos), .index_gate_pos(index_gate_pos), .index_gate_neg(index_gate_neg),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .qa(qa), .qb(qb), .qz(qz));

// >>> verif/sqi_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module sqi_top_tb;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  angle_pos = 6'h00;
  logic        index_gate_pos = 1'b1;
  logic        index_gate_neg = 1'b0;
  logic        test_strap = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        clr = 1'b0;
  logic [7:0]  lfsr = 8'h2c;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        qa;
  logic        qb;
  logic        qz;
  int          pos;
  int          zrise;
  int          min_gap;
  int          bad_count = 0;
  int          tests_run = 0;
  // free running clock
  always #25 clock = ~clock;
  sqi_top sqi_top_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
    .angle_pos(angle_pos), .index_gate_pos(index_gate_pos),
    .index_gate_neg(index_gate_neg),
    .test_strap(test_strap), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .qa(qa), .qb(qb), .qz(qz));
  sqi_counter_model sqi_counter_model_inst (.clock(clock), .sys_rst(sys_rst),
    .clr(clr), .qa(qa), .qb(qb), .qz(qz), .pos(pos), .zrise(zrise), .min_gap(min_gap));
  // next value of the random source
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // factor from {sel1, sel0}
  function automatic int exp_fac(input logic [3:0] s);
    case (s)
      4'ha: return 16;
      4'h9: return 12;
      4'h8: return 10;
      4'h6: return 8;
      4'h5: return 5;
      4'h4: return 4;
      4'h2: return 3;
      4'h1: return 2;
      default: return 1;
    endcase
  endfunction
  // counts and verdict
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // wait for ready, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
  endtask
  // one single word transfer, read data into rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // move the angle n steps, random jumps of one or two
  task automatic walk(input int n, input int d);
    int k;
    int j;
    k = 0;
    while (k < n)
    begin
      j = (lfsr[0] && k + 1 < n) ? 2 : 1;
      lfsr = nxt(lfsr);
      angle_pos <= angle_pos + 6'(j * d);
      repeat (12 * j) @(posedge clock);
      k += j;
    end
  endtask
  // set ctrl, then four steps and one input cycle forward
  task automatic run(input logic [7:0] c, input logic g, input int dp, input int dz);
    int p0;
    int z0;
    index_gate_pos <= g;
    bus(1'b1, 32'h0, {24'h0, c});
    repeat (4) @(posedge clock);
    bus(1'b0, 32'hc, 32'h0);
    `CHK(rd[20:16], 5'(exp_fac(c[3:0])))
    walk(4, 1);
    p0 = pos;
    z0 = zrise;
    walk(64, 1);
    `CHK(pos - p0, dp)
    `CHK(zrise - z0, dz)
    $display("run %h done", c);
  endtask
  // main sequence
  initial
  begin
    int i;
    int p0;
    logic [3:0] s;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    bus(1'b0, 32'h8, 32'h0);
    `CHK(rd, 32'h7)
    test_strap <= 1'b0;
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b0, 32'h8, 32'h0);
    `CHK(rd, 32'h5)
    bus(1'b0, 32'h10, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'h0a)
    $display("registers done");
    for (i = 0; i < 9; i++)
    begin
      s = {2'(2 - i / 3), 2'(2 - i % 3)};
      run({4'h0, s}, 1'b1, 4 * exp_fac(s), 1);
    end
    run(8'h2a, 1'b1, -64, 1);
    run(8'h1a, 1'b0, 64, 1);
    run(8'h4a, 1'b1, 64, 1);
    run(8'h0a, 1'b0, 64, 0);
    index_gate_neg <= 1'b1;
    run(8'h0a, 1'b1, 64, 0);
    index_gate_neg <= 1'b0;
    p0 = pos;
    walk(1, -1);
    `CHK(pos, p0)
    walk(9, -1);
    p0 = pos;
    walk(64, -1);
    `CHK(pos - p0, -64)
    p0 = pos;
    repeat (250) @(posedge clock);
    `CHK(pos, p0)
    $display("reversal done");
    bus(1'b1, 32'h10, 32'h3);
    bus(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'h0a)
    bus(1'b0, 32'h8, 32'h0);
    `CHK(rd, 32'h5)
    bus(1'b1, 32'h4, 32'h4);
    bus(1'b0, 32'h4, 32'h0);
    `CHK(rd, 32'h4)
    bus(1'b1, 32'h0, 32'h6);
    repeat (4) @(posedge clock);
    walk(4, 1);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    p0 = pos;
    angle_pos <= angle_pos + 6'h10;
    repeat (200) @(posedge clock);
    `CHK(min_gap, 10)
    `CHK(pos - p0, 8)
    $display("spacing done");
    conclude();
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clock);
    bad_count++;
    conclude();
  end
endmodule
